//--- core/tlbx_top.sv
// Translation lookaside lookup with register access over AXI4-Lite
`timescale 1ns/100ps

// How it works
// - Entry hits only if its space id equals the current one or global set.
// - Virtual bits 31..11 compared to every entry, masked bits ignored.
// - Each entry keeps the page mask captured when it was written.
// - Without a mask register every entry behaves as a 4KB page.
// - Half chosen by address bit just above the unmasked offset.
// - Without small pages: zero mask picks bit 12, each pair adds two.
// - With small pages: 18-bit mask, zero picks bit 10, up to 28.
// - Select bit zero takes even half, otherwise the odd half.
// - Selected half not valid raises invalid-translation fault.
// - Store to valid selected half with dirty clear raises page-modified fault.
// - Good hit joins frame and coherency with in-page offset bits.
// - Small page lookup used only when support is present.
// - Frame bit zero sits at address bit 12, or 10 with small pages.
// - Address bits below select bit from virtual, above from frame.
module tlbx_top #(
  parameter int ENTRIES = 16,
  parameter bit HAS_MASK_REG = 1'b1,
  parameter bit SMALL_PAGE_SUPPORT = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Lookup request from load/store path
  input wire logic reqValid,
  input wire logic [31:0] reqVaddr,
  input wire logic reqStore,
  // Lookup answer, one cycle later
  output logic rspValid,
  output logic [tlbx_pkg::PHYS_ADDR_WIDTH-1:0] rspPaddr,
  output logic [tlbx_pkg::COH_W-1:0] rspCoh,
  output logic rspMiss,
  output logic rspInvalid,
  output logic rspModified,
  output logic rspStore,
  // Interrupt
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam int PAW = tlbx_pkg::PHYS_ADDR_WIDTH;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into a register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = st[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake state
  logic awRdy_q, awRdy_d, wRdy_q, wRdy_d, arRdy_q, arRdy_d;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic doWrite;

  // Software-visible state
  logic [31:0] key_q, key_d, mask_q, mask_d, even_q, even_d, odd_q, odd_d;
  logic [IDX_W-1:0] index_q, index_d;
  logic en1k_q, en1k_d;
  logic [tlbx_pkg::IRQ_W-1:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d;
  logic irq_q, irq_d;
  logic [31:0] faultVa_q, faultVa_d;
  logic [PAW-1:0] lastPa_q, lastPa_d;

  // Entry storage
  tlbx_pkg::tlbx_entry_t ents_q [ENTRIES];
  tlbx_pkg::tlbx_entry_t ents_d [ENTRIES];

  // Lookup answer registers
  logic rspValid_q, rspValid_d, rspMiss_q, rspMiss_d, rspInv_q, rspInv_d;
  logic rspMod_q, rspMod_d, rspStore_q, rspStore_d;
  logic [PAW-1:0] rspPa_q, rspPa_d;
  logic [tlbx_pkg::COH_W-1:0] rspCoh_q, rspCoh_d;

  // Lookup wiring
  logic hit;
  logic [IDX_W-1:0] hitIdx;
  logic en1kEff;
  tlbx_sel_if selIf ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes, write commit and read answer
  always_comb begin
    awHeld_d = awHeld_q || (s_axi_awvalid && awRdy_q);
    wHeld_d = wHeld_q || (s_axi_wvalid && wRdy_q);
    awAddr_d = (s_axi_awvalid && awRdy_q) ? s_axi_awaddr : awAddr_q;
    wData_d = (s_axi_wvalid && wRdy_q) ? s_axi_wdata : wData_q;
    wStrb_d = (s_axi_wvalid && wRdy_q) ? s_axi_wstrb : wStrb_q;
    doWrite = awHeld_q && wHeld_q && !bValid_q;
    bValid_d = bValid_q && !s_axi_bready;
    bResp_d = bResp_q;
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      unique case (awAddr_q)
        tlbx_pkg::OFS_KEY, tlbx_pkg::OFS_MASK, tlbx_pkg::OFS_EVEN, tlbx_pkg::OFS_ODD,
        tlbx_pkg::OFS_INDEX, tlbx_pkg::OFS_CMD, tlbx_pkg::OFS_CFG, tlbx_pkg::OFS_IRQ_EN,
        tlbx_pkg::OFS_IRQ_CLR: bResp_d = tlbx_pkg::RESP_OKAY;
        default: bResp_d = tlbx_pkg::RESP_SLVERR;
      endcase
    end
    awRdy_d = !awHeld_d;
    wRdy_d = !wHeld_d;
    rValid_d = rValid_q && !s_axi_rready;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (s_axi_arvalid && arRdy_q) begin
      rValid_d = 1'b1;
      rResp_d = tlbx_pkg::RESP_OKAY;
      rData_d = '0;
      unique case (s_axi_araddr)
        tlbx_pkg::OFS_KEY: rData_d = key_q;
        tlbx_pkg::OFS_MASK: rData_d = mask_q;
        tlbx_pkg::OFS_EVEN: rData_d = even_q;
        tlbx_pkg::OFS_ODD: rData_d = odd_q;
        tlbx_pkg::OFS_INDEX: rData_d = 32'(index_q);
        tlbx_pkg::OFS_CMD, tlbx_pkg::OFS_IRQ_CLR: rData_d = '0;
        tlbx_pkg::OFS_CFG: begin
          rData_d[tlbx_pkg::CFG_EN1K_BIT] = en1k_q;
          rData_d[tlbx_pkg::CFG_CAP1K_BIT] = SMALL_PAGE_SUPPORT;
        end
        tlbx_pkg::OFS_IRQ_STAT: rData_d = 32'(irqStat_q);
        tlbx_pkg::OFS_IRQ_EN: rData_d = 32'(irqEn_q);
        tlbx_pkg::OFS_FAULT_VA: rData_d = faultVa_q;
        tlbx_pkg::OFS_LAST_PA: rData_d = 32'(lastPa_q);
        default: rResp_d = tlbx_pkg::RESP_SLVERR;
      endcase
    end
    arRdy_d = !rValid_d;
  end

  // Bus handshake registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awRdy_q <= 1'b0;
      wRdy_q <= 1'b0;
      arRdy_q <= 1'b0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= 2'h0;
      rValid_q <= 1'b0;
      rResp_q <= 2'h0;
      rData_q <= 32'h0000_0000;
    end else begin
      awRdy_q <= awRdy_d;
      wRdy_q <= wRdy_d;
      arRdy_q <= arRdy_d;
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, entry load and interrupt status
  always_comb begin
    key_d = key_q;
    mask_d = mask_q;
    even_d = even_q;
    odd_d = odd_q;
    index_d = index_q;
    en1k_d = en1k_q;
    irqEn_d = irqEn_q;
    irqStat_d = irqStat_q;
    ents_d = ents_q;
    if (doWrite) begin
      unique case (awAddr_q)
        tlbx_pkg::OFS_KEY: key_d = merge(key_q, wData_q, wStrb_q);
        tlbx_pkg::OFS_MASK: mask_d = merge(mask_q, wData_q, wStrb_q);
        tlbx_pkg::OFS_EVEN: even_d = merge(even_q, wData_q, wStrb_q);
        tlbx_pkg::OFS_ODD: odd_d = merge(odd_q, wData_q, wStrb_q);
        tlbx_pkg::OFS_INDEX: index_d = wData_q[IDX_W-1:0];
        tlbx_pkg::OFS_CFG: en1k_d = wData_q[tlbx_pkg::CFG_EN1K_BIT];
        tlbx_pkg::OFS_IRQ_EN: irqEn_d = wData_q[tlbx_pkg::IRQ_W-1:0];
        tlbx_pkg::OFS_IRQ_CLR: irqStat_d = irqStat_q & ~wData_q[tlbx_pkg::IRQ_W-1:0];
        tlbx_pkg::OFS_CMD: begin
          if (wData_q[tlbx_pkg::CMD_WRITE_BIT] && 32'(index_q) < ENTRIES) begin
            ents_d[index_q].vpn = key_q[tlbx_pkg::KEY_VPN_LSB +: tlbx_pkg::VPN_W];
            ents_d[index_q].address_space_id = key_q[tlbx_pkg::KEY_ADDRESS_SPACE_ID_LSB +: tlbx_pkg::ADDRESS_SPACE_ID_W];
            ents_d[index_q].glb = key_q[tlbx_pkg::KEY_GLB_BIT];
            ents_d[index_q].mask = HAS_MASK_REG ? mask_q[tlbx_pkg::MASK_LSB +: tlbx_pkg::MASK_W]
              : tlbx_pkg::MASK_4KB;
            ents_d[index_q].even = {even_q[tlbx_pkg::LO_PFN_LSB +: tlbx_pkg::PFN_W],
              even_q[tlbx_pkg::LO_C_LSB +: tlbx_pkg::COH_W], even_q[tlbx_pkg::LO_D_BIT],
              even_q[tlbx_pkg::LO_V_BIT]};
            ents_d[index_q].odd = {odd_q[tlbx_pkg::LO_PFN_LSB +: tlbx_pkg::PFN_W],
              odd_q[tlbx_pkg::LO_C_LSB +: tlbx_pkg::COH_W], odd_q[tlbx_pkg::LO_D_BIT],
              odd_q[tlbx_pkg::LO_V_BIT]};
          end
        end
        default: ;
      endcase
    end
    // Fault events set status; a set beats a same-cycle clear
    irqStat_d[tlbx_pkg::IRQ_MISS] = irqStat_d[tlbx_pkg::IRQ_MISS] | rspMiss_d;
    irqStat_d[tlbx_pkg::IRQ_INV] = irqStat_d[tlbx_pkg::IRQ_INV] | rspInv_d;
    irqStat_d[tlbx_pkg::IRQ_MOD] = irqStat_d[tlbx_pkg::IRQ_MOD] | rspMod_d;
    irq_d = |(irqStat_d & irqEn_d);
  end

  // Register and entry storage flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      key_q <= 32'h0000_0000;
      mask_q <= 32'h0000_0000;
      even_q <= 32'h0000_0000;
      odd_q <= 32'h0000_0000;
      index_q <= '0;
      en1k_q <= 1'b0;
      irqEn_q <= '0;
      irqStat_q <= '0;
      irq_q <= 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
        ents_q[i] <= '0;
      end
    end else begin
      key_q <= key_d;
      mask_q <= mask_d;
      even_q <= even_d;
      odd_q <= odd_d;
      index_q <= index_d;
      en1k_q <= en1k_d;
      irqEn_q <= irqEn_d;
      irqStat_q <= irqStat_d;
      irq_q <= irq_d;
      ents_q <= ents_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel lookup
  assign en1kEff = SMALL_PAGE_SUPPORT && en1k_q;

  tlbx_match #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_match (
    .ents(ents_q),
    .vpn(reqVaddr[31:tlbx_pkg::VA_VPN_LSB]),
    .address_space_id(key_q[tlbx_pkg::KEY_ADDRESS_SPACE_ID_LSB +: tlbx_pkg::ADDRESS_SPACE_ID_W]),
    .en1k(en1kEff),
    .hit(hit),
    .idx(hitIdx)
  );

  // Hand the winning entry to the translation stage
  assign selIf.en1k = en1kEff;
  assign selIf.va = reqVaddr;
  assign selIf.store = reqStore;
  assign selIf.ent = ents_q[hitIdx];

  tlbx_xlate u_xlate (
    .sel(selIf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answer to the load/store path
  always_comb begin
    rspValid_d = reqValid;
    rspStore_d = reqStore;
    rspMiss_d = reqValid && !hit;
    rspInv_d = reqValid && hit && selIf.invalid;
    rspMod_d = reqValid && hit && selIf.modified;
    rspPa_d = '0;
    rspCoh_d = '0;
    lastPa_d = lastPa_q;
    faultVa_d = faultVa_q;
    if (reqValid && hit && !selIf.invalid && !selIf.modified) begin
      rspPa_d = selIf.paddr;
      rspCoh_d = selIf.coh;
      lastPa_d = selIf.paddr;
    end
    if (rspMiss_d || rspInv_d || rspMod_d) begin
      faultVa_d = reqVaddr;
    end
  end

  // Answer registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rspValid_q <= 1'b0;
      rspStore_q <= 1'b0;
      rspMiss_q <= 1'b0;
      rspInv_q <= 1'b0;
      rspMod_q <= 1'b0;
      rspPa_q <= '0;
      rspCoh_q <= '0;
      lastPa_q <= '0;
      faultVa_q <= 32'h0000_0000;
    end else begin
      rspValid_q <= rspValid_d;
      rspStore_q <= rspStore_d;
      rspMiss_q <= rspMiss_d;
      rspInv_q <= rspInv_d;
      rspMod_q <= rspMod_d;
      rspPa_q <= rspPa_d;
      rspCoh_q <= rspCoh_d;
      lastPa_q <= lastPa_d;
      faultVa_q <= faultVa_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign rspValid = rspValid_q;
  assign rspPaddr = rspPa_q;
  assign rspCoh = rspCoh_q;
  assign rspMiss = rspMiss_q;
  assign rspInvalid = rspInv_q;
  assign rspModified = rspMod_q;
  assign rspStore = rspStore_q;
  assign irq = irq_q;
  assign s_axi_awready = awRdy_q;
  assign s_axi_wready = wRdy_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arRdy_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
endmodule : tlbx_top

//--- common/tlbx_pkg.sv
// Shared constants, types and decode functions of the translation lookup
package tlbx_pkg;
  localparam int PHYS_ADDR_WIDTH = 32;
  localparam int PFN_W = PHYS_ADDR_WIDTH - 10;
  localparam int VPN_W = 21;
  localparam int MASK_W = 18;
  localparam int ADDRESS_SPACE_ID_W = 8;
  localparam int COH_W = 3;
  localparam int SEL_W = 5;
  localparam int IRQ_W = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_KEY = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_EVEN = 8'h08;
  localparam logic [7:0] OFS_ODD = 8'h0c;
  localparam logic [7:0] OFS_INDEX = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_CFG = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFS_FAULT_VA = 8'h28;
  localparam logic [7:0] OFS_LAST_PA = 8'h2c;
  // Field positions
  localparam int KEY_ADDRESS_SPACE_ID_LSB = 0;
  localparam int KEY_GLB_BIT = 8;
  localparam int KEY_VPN_LSB = 11;
  localparam int MASK_LSB = 11;
  localparam int LO_V_BIT = 0;
  localparam int LO_D_BIT = 1;
  localparam int LO_C_LSB = 2;
  localparam int LO_PFN_LSB = 10;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CFG_EN1K_BIT = 0;
  localparam int CFG_CAP1K_BIT = 1;
  localparam int IRQ_MISS = 0;
  localparam int IRQ_INV = 1;
  localparam int IRQ_MOD = 2;
  // Page geometry
  localparam int SEL_1KB = 10;
  localparam int SEL_STEP = 2;
  localparam int PAIRS = 9;
  localparam int SHIFT_1KB = 10;
  localparam int SHIFT_4KB = 12;
  localparam int VA_VPN_LSB = 11;
  localparam logic [MASK_W-1:0] MASK_4KB = 18'h00003;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [PFN_W-1:0] pfn;
    logic [COH_W-1:0] coh;
    logic dirty;
    logic valid;
  } tlbx_half_t;

  typedef struct packed {
    logic [VPN_W-1:0] vpn;
    logic [MASK_W-1:0] mask;
    logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
    logic glb;
    tlbx_half_t even;
    tlbx_half_t odd;
  } tlbx_entry_t;

  // Without small pages the extension bits are always ignored
  function automatic logic [MASK_W-1:0] effMask(input logic [MASK_W-1:0] m, input logic en1k);
    effMask = en1k ? m : (m | MASK_4KB);
  endfunction : effMask

  // Address bit that picks the even or odd half
  function automatic logic [SEL_W-1:0] pairSelect(input logic [MASK_W-1:0] m);
    logic run;
    pairSelect = SEL_W'(SEL_1KB);
    run = 1'b1;
    for (int k = 0; k < PAIRS; k++) begin
      run = run & m[2*k] & m[2*k+1];
      if (run) begin
        pairSelect = SEL_W'(SEL_1KB + SEL_STEP * (k + 1));
      end
    end
  endfunction : pairSelect
endpackage : tlbx_pkg

//--- common/tlbx_sel_if.sv
// Selected entry and its translation result between lookup stages
`timescale 1ns/100ps
interface tlbx_sel_if;
  logic en1k;
  logic [31:0] va;
  logic store;
  tlbx_pkg::tlbx_entry_t ent;
  logic [tlbx_pkg::PHYS_ADDR_WIDTH-1:0] paddr;
  logic [tlbx_pkg::COH_W-1:0] coh;
  logic invalid;
  logic modified;
  modport src (output en1k, va, store, ent, input paddr, coh, invalid, modified);
  modport xl (input en1k, va, store, ent, output paddr, coh, invalid, modified);
endinterface : tlbx_sel_if

//--- core/tlbx_match.sv
// Parallel compare of all entries with lowest-index priority
`timescale 1ns/100ps
module tlbx_match #(
  parameter int ENTRIES = 16,
  parameter int IDX_W = 4
) (
  // Entry storage
  input wire tlbx_pkg::tlbx_entry_t ents [ENTRIES],
  // Lookup key
  input wire logic [tlbx_pkg::VPN_W-1:0] vpn,
  input wire logic [tlbx_pkg::ADDRESS_SPACE_ID_W-1:0] address_space_id,
  input wire logic en1k,
  // Result
  output logic hit,
  output logic [IDX_W-1:0] idx
);
  logic [ENTRIES-1:0] hits;

  // One comparator per entry
  for (genvar i = 0; i < ENTRIES; i++) begin : g_cmp
    logic [tlbx_pkg::MASK_W-1:0] m;
    assign m = tlbx_pkg::effMask(ents[i].mask, en1k);
    // Mask bit 0 lines up with virtual bit 11; the top three page bits are always compared
    assign hits[i] = (((ents[i].vpn ^ vpn) & ~{3'h0, m}) == '0)
      && (ents[i].glb || ents[i].address_space_id == address_space_id);
  end

  // Lowest matching index wins
  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hits[i]) begin
        hit = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end
endmodule : tlbx_match

//--- core/tlbx_xlate.sv
// Half selection, fault checks and physical address forming
`timescale 1ns/100ps
module tlbx_xlate (
  // Selected entry and result
  tlbx_sel_if.xl sel
);
  localparam int PAW = tlbx_pkg::PHYS_ADDR_WIDTH;
  logic [tlbx_pkg::SEL_W-1:0] selBit;
  tlbx_pkg::tlbx_half_t half;
  logic [PAW-1:0] base;
  logic [PAW-1:0] lowMask;

  // Pick half, check flags, splice frame and offset
  always_comb begin
    selBit = tlbx_pkg::pairSelect(tlbx_pkg::effMask(sel.ent.mask, sel.en1k));
    half = sel.va[selBit] ? sel.ent.odd : sel.ent.even;
    if (sel.en1k) begin
      base = {half.pfn, {tlbx_pkg::SHIFT_1KB{1'b0}}};
    end else begin
      base = {half.pfn[PAW-tlbx_pkg::SHIFT_4KB-1:0], {tlbx_pkg::SHIFT_4KB{1'b0}}};
    end
    lowMask = ~({PAW{1'b1}} << selBit);
    sel.paddr = (base & ~lowMask) | (sel.va[PAW-1:0] & lowMask);
    sel.coh = half.coh;
    sel.invalid = !half.valid;
    sel.modified = half.valid && !half.dirty && sel.store;
  end
endmodule : tlbx_xlate

//--- tb/tlbx_lsu_model.sv
// Load/store pipeline model that issues lookups and catches the answers
`timescale 1ns/100ps
module tlbx_lsu_model (
  // Clock
  input wire logic mclk,
  // Request side
  output logic reqValid,
  output logic [31:0] reqVaddr,
  output logic reqStore,
  // Answer side
  input wire logic rspValid,
  input wire logic [31:0] rspPaddr,
  input wire logic [2:0] rspCoh,
  input wire logic [3:0] rspFlags
);
  logic [39:0] got;

  // Idle before the first request
  initial begin
    reqValid = 1'b0;
    reqVaddr = 32'h0;
    reqStore = 1'b0;
  end

  // One request, answer caught just after the following edge
  task automatic issue(input logic [31:0] va, input logic st);
    @(posedge mclk);
    reqValid <= 1'b1;
    reqVaddr <= va;
    reqStore <= st;
    @(posedge mclk);
    reqValid <= 1'b0;
    reqVaddr <= ~va; // Idle lines never echo the last request
    reqStore <= ~st;
    #1 got = {rspValid, rspFlags, rspCoh, rspPaddr};
  endtask : issue
endmodule : tlbx_lsu_model

//--- tb/tlbx_top_asserts.sv
// Lookup answer checks on the top module ports
`timescale 1ns/100ps
module tlbx_top_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Lookup
  input wire logic reqValid,
  input wire logic [31:0] reqVaddr,
  input wire logic reqStore,
  input wire logic rspValid,
  input wire logic [tlbx_pkg::PHYS_ADDR_WIDTH-1:0] rspPaddr,
  input wire logic [tlbx_pkg::COH_W-1:0] rspCoh,
  input wire logic rspMiss,
  input wire logic rspInvalid,
  input wire logic rspModified,
  input wire logic rspStore
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////
  // Answer timing and outcome
  a_rsp_follows: assert property (reqValid |=> rspValid)
    else $error("no answer one cycle after request");
  a_no_spurious: assert property (!reqValid |=> !(rspValid || rspMiss || rspInvalid || rspModified))
    else $error("answer without request");
  a_one_outcome: assert property (rspValid |-> $onehot0({rspMiss, rspInvalid, rspModified}))
    else $error("more than one fault flag");
  a_store_echo: assert property (reqValid |=> rspStore == $past(reqStore))
    else $error("reference type not echoed");
  a_miss_noaddr: assert property (rspMiss |-> rspPaddr == 32'h0 && rspCoh == 3'h0)
    else $error("miss carries an address");
  a_fault_noaddr: assert property ((rspInvalid || rspModified) |-> rspPaddr == 32'h0)
    else $error("fault carries an address");
  a_mod_store: assert property (rspModified |-> rspStore)
    else $error("modified fault on a load");
  a_offset_kept: assert property ((rspValid && !rspMiss && !rspInvalid && !rspModified)
    |-> rspPaddr[9:0] == $past(reqVaddr[9:0]))
    else $error("page offset not passed through");
endmodule : tlbx_top_asserts

bind tlbx_top tlbx_top_asserts i_chk (.mclk(mclk), .rstn(rstn), .reqValid(reqValid), .reqVaddr(reqVaddr),
  .reqStore(reqStore), .rspValid(rspValid), .rspPaddr(rspPaddr), .rspCoh(rspCoh), .rspMiss(rspMiss),
  .rspInvalid(rspInvalid), .rspModified(rspModified), .rspStore(rspStore));

//--- tb/tlbx_top_test.sv
// Self-checking bench of the translation lookup
`timescale 1ns/100ps
module tlbx_top_test;
  logic mclk, rstn, reqValid, reqStore, rspValid, rspMiss, rspInvalid, rspModified, rspStore, irq;
  logic [31:0] reqVaddr, rspPaddr, wdata, rdata;
  logic [2:0] rspCoh;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int fails, total_checks, cyc;
  localparam logic [31:0] EV = 32'h048d140f; // Valid, dirty, coherency 3
  localparam logic [31:0] OD = 32'h0aaf3415; // Valid, clean, coherency 5
  localparam logic [31:0] EVI = 32'h048d140e; // Dirty but not valid
  localparam logic [1:0] OK = tlbx_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = tlbx_pkg::RESP_SLVERR;

  tlbx_top i_dut (.mclk(mclk), .rstn(rstn), .reqValid(reqValid), .reqVaddr(reqVaddr), .reqStore(reqStore),
    .rspValid(rspValid), .rspPaddr(rspPaddr), .rspCoh(rspCoh), .rspMiss(rspMiss), .rspInvalid(rspInvalid),
    .rspModified(rspModified), .rspStore(rspStore), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tlbx_lsu_model i_lsu (.mclk(mclk), .reqValid(reqValid), .reqVaddr(reqVaddr), .reqStore(reqStore),
    .rspValid(rspValid), .rspPaddr(rspPaddr), .rspCoh(rspCoh),
    .rspFlags({rspMiss, rspInvalid, rspModified, rspStore}));

  ////////////////////////////////////////////////////////////////////////
  // Compare, report, verdict
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  // Register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge mclk); while (!bvalid);
    chk(bresp, er);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge mclk);
    chk({rresp, rdata}, {er, d});
    rready <= 1'b0;
  endtask : rd

  // Load one entry through the staging registers
  task automatic ent(input logic [3:0] i, input logic [31:0] k, m, e, o);
    wr(8'h00, k, OK);
    wr(8'h04, m, OK);
    wr(8'h08, e, OK);
    wr(8'h0c, o, OK);
    wr(8'h10, {28'h0, i}, OK);
    wr(8'h14, 32'h1, OK);
    repeat (2) @(posedge mclk);
  endtask : ent

  // Expected address: frame above the select bit, offset below it
  function automatic logic [31:0] xpa(input logic [31:0] va, lo, input int s, input logic k1);
    logic [31:0] b;
    logic [31:0] m;
    b = k1 ? {lo[31:10], 10'h0} : {lo[29:10], 12'h0};
    m = (32'h1 << s) - 32'h1;
    return (b & ~m) | (va & m);
  endfunction : xpa
  task automatic look(input logic [31:0] va, input logic st, input logic [2:0] f, input logic [31:0] lo,
    input int s, input logic k1);
    logic [31:0] pa;
    pa = (f == 3'h0) ? xpa(va, lo, s, k1) : 32'h0;
    i_lsu.issue(va, st);
    chk(i_lsu.got, {1'b1, f, st, (f == 3'h0) ? lo[4:2] : 3'h0, pa});
  endtask : look

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    rd(8'h18, 32'h2, OK);
    rd(8'h40, 32'h0, ERR);
    wr(8'h1c, 32'h1, ERR);
    wr(8'h3c, 32'h1, ERR);
    wstrb <= 4'h1;
    wr(8'h00, 32'hffffffff, OK);
    wstrb <= 4'hf;
    rd(8'h00, 32'h000000ff, OK);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_4k();
    ent(4'h0, 32'h80000005, 32'h0, EV, OD);
    look(32'h80000abc, 1'b0, 3'h0, EV, 12, 1'b0);
    look(32'h80001abc, 1'b1, 3'h1, OD, 12, 1'b0);
    look(32'h80001abc, 1'b0, 3'h0, OD, 12, 1'b0);
    look(32'h80002abc, 1'b0, 3'h4, OD, 12, 1'b0);
    wr(8'h00, 32'h80000006, OK);
    look(32'h80000abc, 1'b1, 3'h4, EV, 12, 1'b0);
    ent(4'h0, 32'h80000105, 32'h0, EV, OD);
    wr(8'h00, 32'h80000006, OK);
    look(32'h80000abc, 1'b1, 3'h0, EV, 12, 1'b0);
    $display("t_4k done");
  endtask : t_4k
  task automatic t_inv();
    ent(4'h3, 32'hc0000000, 32'h0, EVI, OD);
    ent(4'h5, 32'hc0000000, 32'h0, EV, OD);
    look(32'hc0000010, 1'b1, 3'h2, EV, 12, 1'b0);
    $display("t_inv done");
  endtask : t_inv
  task automatic t_1k();
    wr(8'h18, 32'h1, OK);
    rd(8'h18, 32'h3, OK);
    ent(4'h6, 32'h90000000, 32'h0, EV, OD);
    look(32'h90000123, 1'b0, 3'h0, EV, 10, 1'b1);
    look(32'h90000523, 1'b0, 3'h0, OD, 10, 1'b1);
    ent(4'h6, 32'h90000000, 32'h1800, EV, OD);
    look(32'h90001523, 1'b0, 3'h0, OD, 12, 1'b1);
    wr(8'h18, 32'h0, OK);
    look(32'h90001523, 1'b0, 3'h0, OD, 12, 1'b0);
    $display("t_1k done");
  endtask : t_1k
  task automatic t_sizes();
    logic [31:0] va;
    for (int s = 12; s <= 28; s += 2) begin
      va = 32'h5a5a5a5a | (32'h1 << s);
      ent(4'h0, va & 32'hfffff800, ((32'h1 << (s - 12)) - 32'h1) << 13, EV, OD);
      look(va, 1'b0, 3'h0, OD, s, 1'b0);
      look(va & ~(32'h1 << s), 1'b1, 3'h0, EV, s, 1'b0);
    end
    $display("t_sizes done");
  endtask : t_sizes
  task automatic t_irq();
    wr(8'h24, 32'h7, OK);
    wr(8'h20, 32'h2, OK);
    look(32'h10000000, 1'b0, 3'h4, EV, 12, 1'b0);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    rd(8'h1c, 32'h1, OK);
    wr(8'h20, 32'h1, OK);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    wr(8'h24, 32'h1, OK);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    rd(8'h1c, 32'h0, OK);
    $display("t_irq done");
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    rstn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_4k();
    t_inv();
    t_1k();
    t_sizes();
    t_irq();
    print_verdict();
  end
endmodule : tlbx_top_test
